/* File: hw/exc_seq_defs.svh */
// Constants for the exception entry and exit sequencer
`ifndef EXC_SEQ_DEFS_SVH
`define EXC_SEQ_DEFS_SVH
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_ABT 5'h17
`define MODE_UND 5'h1B
`define BIT_T 5
`define BIT_F 6
`define BIT_I 7
`define BIT_J 24
`define STATUS_RST 32'h000000D3
`define VEC_HIGH_BASE 32'hFFFF0000
`define VEC_RST 32'h00000000
`define VEC_UND 32'h00000004
`define VEC_SWI 32'h00000008
`define VEC_PREFETCH_ABORT_EXC 32'h0000000C
`define VEC_DATA_ABORT_EXC 32'h00000010
`define VEC_IRQ 32'h00000018
`define VEC_FIQ 32'h0000001C
`define OFS_NATIVE 32'h00000004
`define OFS_COMP 32'h00000002
`define OFS_DATA_ABORT_EXC 32'h00000008
`define REG_STATUS 8'h00
`define REG_SAVED 8'h04
`define REG_LINK 8'h08
`define REG_CAUSE 8'h0C
`endif

/* File: hw/exc_seq_pkg.sv */
// Types for the exception entry and exit sequencer
package exc_seq_pkg;
  typedef enum logic [1:0] {PH_HOLD = 2'b00, PH_BOOT = 2'b01, PH_RUN = 2'b11} phase_t;
  typedef enum logic [3:0] {
    EXC_NONE = 4'h0, EXC_RST = 4'h1, EXC_UND = 4'h2, EXC_SWI = 4'h3, EXC_PREFETCH_ABORT_EXC = 4'h4,
    EXC_DATA_ABORT_EXC = 4'h5, EXC_IRQ = 4'h6, EXC_FIQ = 4'h7, EXC_BREAKPOINT_TRAP = 4'h8
  } exc_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    phase_t phase;
    logic fiq_q;
    logic irq_q;
    logic dec_tag;
    logic exe_tag;
    logic dab_pend;
    logic [31:0] dab_pc;
    logic [31:0] cur;
    logic [4:0][31:0] saved;
    logic [31:0] lr_val;
    logic lr_we;
    logic [4:0] lr_mode;
    logic redirect;
    logic [31:0] vec;
    logic restore_base;
    logic abandon;
    exc_t cause;
    logic ack;
    logic [31:0] rdat;
  } state_t;
endpackage : exc_seq_pkg

/* File: hw/exc_seq.sv */
// Exception entry/exit sequencer with classic Wishbone status access
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "exc_seq_defs.svh"
module exc_seq import exc_seq_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic fast_int_request_low,
  input wire logic normal_int_request_low,
  input wire logic fetch_done_in,
  input wire logic fetch_abort_in,
  input wire logic advance_in,
  input wire logic flush_in,
  input wire logic data_done_in,
  input wire logic data_abort_in,
  input wire logic [31:0] data_pc_in,
  input wire logic instr_end_in,
  input wire logic [31:0] exec_pc_in,
  input wire logic [31:0] next_pc_in,
  input wire logic software_trap,
  input wire logic undefined_trap,
  input wire logic breakpoint_trap,
  input wire logic restore_in,
  input wire logic high_vector_select,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic [31:0] current_status_word,
  output logic [31:0] link_register,
  output logic link_write_out,
  output logic [4:0] link_mode_out,
  output logic redirect_out,
  output logic [31:0] vector_addr_out,
  output logic base_restore_out,
  output logic abandon_out
);
  localparam state_t RESET_STATE = '{phase: PH_HOLD, cur: `STATUS_RST, abandon: 1'b1,
                                     fiq_q: 1'b1, irq_q: 1'b1, cause: EXC_NONE, default: '0};
  state_t s_ff;
  state_t nxt_s;
  wb_req_t req;
  logic [31:0] base;
  logic [2:0] base_idx;
  logic base_has;
  logic [2:0] tgt_idx;
  logic tgt_has;
  logic [31:0] wmask;
  exc_t pick;

  // Saved status slot for a mode; user and system modes have none
  function automatic logic [3:0] slot(input logic [4:0] mode);
    case (mode)
      `MODE_FIQ: slot = 4'h8;
      `MODE_IRQ: slot = 4'h9;
      `MODE_SVC: slot = 4'hA;
      `MODE_ABT: slot = 4'hB;
      `MODE_UND: slot = 4'hC;
      default: slot = 4'h0;
    endcase
  endfunction : slot

  function automatic logic [4:0] exc_mode(input exc_t e);
    case (e)
      EXC_FIQ: exc_mode = `MODE_FIQ;
      EXC_IRQ: exc_mode = `MODE_IRQ;
      EXC_PREFETCH_ABORT_EXC, EXC_DATA_ABORT_EXC, EXC_BREAKPOINT_TRAP: exc_mode = `MODE_ABT;
      EXC_UND: exc_mode = `MODE_UND;
      default: exc_mode = `MODE_SVC;
    endcase
  endfunction : exc_mode

  function automatic logic [31:0] exc_ofs(input exc_t e);
    case (e)
      EXC_UND: exc_ofs = `VEC_UND;
      EXC_SWI: exc_ofs = `VEC_SWI;
      EXC_PREFETCH_ABORT_EXC, EXC_BREAKPOINT_TRAP: exc_ofs = `VEC_PREFETCH_ABORT_EXC;
      EXC_DATA_ABORT_EXC: exc_ofs = `VEC_DATA_ABORT_EXC;
      EXC_IRQ: exc_ofs = `VEC_IRQ;
      EXC_FIQ: exc_ofs = `VEC_FIQ;
      default: exc_ofs = `VEC_RST;
    endcase
  endfunction : exc_ofs

  assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in, adr: wb_adr_in,
                 sel: wb_sel_in, dat: wb_dat_in};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.lr_we = 1'b0;
    nxt_s.redirect = 1'b0;
    nxt_s.restore_base = 1'b0;
    nxt_s.abandon = 1'b0;
    nxt_s.ack = 1'b0;
    // Control logic reads only the registered copies
    nxt_s.fiq_q = fast_int_request_low;
    nxt_s.irq_q = normal_int_request_low;
    if (fetch_done_in) begin
      nxt_s.dec_tag = fetch_abort_in;
    end
    if (advance_in) begin
      nxt_s.exe_tag = s_ff.dec_tag;
    end
    if (flush_in) begin
      nxt_s.dec_tag = 1'b0;
      nxt_s.exe_tag = 1'b0;
    end
    if (data_done_in && data_abort_in) begin
      nxt_s.dab_pend = 1'b1;
      nxt_s.dab_pc = data_pc_in;
    end
    {base_has, base_idx} = slot(s_ff.cur[4:0]);
    base = s_ff.cur;
    if (restore_in && base_has) begin
      base = s_ff.saved[base_idx];
    end
    nxt_s.cur = base;
    // Software status writes cannot touch the state bits
    wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
    if (req.cyc && req.stb && s_ff.ack && req.we) begin
      if (req.adr == `REG_STATUS) begin
        nxt_s.cur = (base & ~wmask) | (req.dat & wmask);
        nxt_s.cur[`BIT_T] = base[`BIT_T];
        nxt_s.cur[`BIT_J] = base[`BIT_J];
      end else if (req.adr == `REG_SAVED && base_has) begin
        nxt_s.saved[base_idx] = (s_ff.saved[base_idx] & ~wmask) | (req.dat & wmask);
      end
    end
    if (req.cyc && req.stb && !s_ff.ack) begin
      nxt_s.ack = 1'b1;
      if (req.adr == `REG_STATUS) begin
        nxt_s.rdat = s_ff.cur;
      end else if (req.adr == `REG_SAVED) begin
        nxt_s.rdat = base_has ? s_ff.saved[base_idx] : 32'h00000000;
      end else if (req.adr == `REG_LINK) begin
        nxt_s.rdat = s_ff.lr_val;
      end else if (req.adr == `REG_CAUSE) begin
        nxt_s.rdat = {28'h0000000, s_ff.cause};
      end else begin
        nxt_s.rdat = 32'h00000000;
      end
    end
    // Priority is sampled only at an instruction boundary
    pick = EXC_NONE;
    if (instr_end_in && s_ff.phase == PH_RUN) begin
      if (s_ff.dab_pend) begin
        pick = EXC_DATA_ABORT_EXC;
      end else if (!s_ff.fiq_q && !base[`BIT_F]) begin
        pick = EXC_FIQ;
      end else if (!s_ff.irq_q && !base[`BIT_I]) begin
        pick = EXC_IRQ;
      end else if (s_ff.exe_tag) begin
        pick = EXC_PREFETCH_ABORT_EXC;
      end else if (breakpoint_trap) begin
        pick = EXC_BREAKPOINT_TRAP;
      end else if (undefined_trap) begin
        pick = EXC_UND;
      end else if (software_trap) begin
        pick = EXC_SWI;
      end
    end
    {tgt_has, tgt_idx} = slot(exc_mode(pick));
    case (s_ff.phase)
      PH_HOLD: begin
        nxt_s.phase = PH_BOOT;
      end
      PH_BOOT: begin
        // Supervisor link is left as is at reset
        nxt_s.redirect = 1'b1;
        nxt_s.vec = (high_vector_select ? `VEC_HIGH_BASE : 32'h00000000) | `VEC_RST;
        nxt_s.cause = EXC_RST;
        nxt_s.phase = PH_RUN;
      end
      PH_RUN: begin
        if (pick != EXC_NONE) begin
          // All entry effects land on the same edge
          nxt_s.saved[tgt_idx] = base;
          nxt_s.cur[4:0] = exc_mode(pick);
          nxt_s.cur[`BIT_T] = 1'b0;
          nxt_s.cur[`BIT_J] = 1'b0;
          nxt_s.cur[`BIT_I] = 1'b1;
          if (pick == EXC_FIQ) begin
            nxt_s.cur[`BIT_F] = 1'b1;
          end
          nxt_s.vec = (high_vector_select ? `VEC_HIGH_BASE : 32'h00000000) |
                      exc_ofs(pick);
          nxt_s.redirect = 1'b1;
          nxt_s.lr_we = 1'b1;
          nxt_s.lr_mode = exc_mode(pick);
          nxt_s.cause = pick;
          nxt_s.dec_tag = 1'b0;
          nxt_s.exe_tag = 1'b0;
          case (pick)
            EXC_DATA_ABORT_EXC: begin
              nxt_s.lr_val = s_ff.dab_pc + `OFS_DATA_ABORT_EXC;
              nxt_s.restore_base = 1'b1;
              nxt_s.dab_pend = 1'b0;
            end
            EXC_FIQ, EXC_IRQ: begin
              nxt_s.lr_val = next_pc_in + `OFS_NATIVE;
            end
            EXC_PREFETCH_ABORT_EXC, EXC_BREAKPOINT_TRAP: begin
              nxt_s.lr_val = exec_pc_in + `OFS_NATIVE;
            end
            default: begin
              nxt_s.lr_val = exec_pc_in + (base[`BIT_T] ? `OFS_COMP : `OFS_NATIVE);
            end
          endcase
        end
      end
      default: begin
        nxt_s.phase = PH_HOLD;
      end
    endcase
  end

  // Reset state holds supervisor mode, both masks, native state
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_ff <= RESET_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_dat_out = s_ff.rdat;
  assign wb_ack_out = s_ff.ack;
  assign current_status_word = s_ff.cur;
  assign link_register = s_ff.lr_val;
  assign link_write_out = s_ff.lr_we;
  assign link_mode_out = s_ff.lr_mode;
  assign redirect_out = s_ff.redirect;
  assign vector_addr_out = s_ff.vec;
  assign base_restore_out = s_ff.restore_base;
  assign abandon_out = s_ff.abandon;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  fiq_masks_a: assert property (redirect_out && s_ff.cause == EXC_FIQ |->
    current_status_word[`BIT_I] && current_status_word[`BIT_F])
    else $error("fast entry left a mask clear");
  irq_f_kept_a: assert property (instr_end_in &&
    s_ff.phase == PH_RUN && !s_ff.dab_pend &&
    (s_ff.fiq_q || base[`BIT_F]) && !s_ff.irq_q && !base[`BIT_I] |=>
    redirect_out && s_ff.cause == EXC_IRQ && current_status_word[`BIT_I] &&
    current_status_word[`BIT_F] == $past(base[`BIT_F]))
    else $error("normal entry wrong masks");
  native_entry_a: assert property (redirect_out |->
    !current_status_word[`BIT_T] && !current_status_word[`BIT_J])
    else $error("entry not in native state");
  dab_link_a: assert property (redirect_out && s_ff.cause == EXC_DATA_ABORT_EXC |->
    link_register == s_ff.dab_pc + `OFS_DATA_ABORT_EXC && base_restore_out && link_mode_out == `MODE_ABT)
    else $error("data abort link wrong");
  fiq_taken_a: assert property (instr_end_in &&
    s_ff.phase == PH_RUN && !s_ff.dab_pend &&
    !s_ff.fiq_q && !base[`BIT_F] |=> redirect_out && s_ff.cause == EXC_FIQ &&
    vector_addr_out[7:0] == 8'h1C)
    else $error("unmasked fast request missed");
  boot_vector_a: assert property ($rose(s_ff.phase == PH_BOOT) |=>
    redirect_out && s_ff.cause == EXC_RST && vector_addr_out[15:0] == 16'h0000 && !link_write_out)
    else $error("reset vector fetch missing");
  saved_copy_a: assert property (redirect_out && s_ff.cause != EXC_RST |->
    s_ff.saved[slot(current_status_word[4:0]) & 4'h7] == $past(base))
    else $error("saved status not copied");
  dab_first_a: assert property (instr_end_in && s_ff.phase == PH_RUN && s_ff.dab_pend |=>
    s_ff.cause == EXC_DATA_ABORT_EXC && !s_ff.dab_pend)
    else $error("data abort lost priority");
  trap_link_a: assert property (instr_end_in &&
    s_ff.phase == PH_RUN && !s_ff.dab_pend &&
    (s_ff.fiq_q || base[`BIT_F]) && (s_ff.irq_q || base[`BIT_I]) && !s_ff.exe_tag &&
    !breakpoint_trap && undefined_trap |=>
    link_register == $past(exec_pc_in) + ($past(base[`BIT_T]) ? `OFS_COMP : `OFS_NATIVE))
    else $error("trap link offset wrong");

  fiq_seen_c: cover property (redirect_out && s_ff.cause == EXC_FIQ);
  dab_seen_c: cover property (redirect_out && s_ff.cause == EXC_DATA_ABORT_EXC);
  prefetch_abort_exc_seen_c: cover property (redirect_out && s_ff.cause == EXC_PREFETCH_ABORT_EXC);
  restore_seen_c: cover property (restore_in ##1 redirect_out);
endmodule : exc_seq

/* File: verification/exc_far_model.sv */
// Interrupt sources and memory abort responder facing the sequencer
`timescale 1ns/100ps
module exc_far_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic fiq_on_in,
  input wire logic irq_on_in,
  input wire logic fetch_go_in,
  input wire logic data_go_in,
  input wire logic fail_in,
  output logic fast_low_out,
  output logic normal_low_out,
  output logic fetch_done_out,
  output logic fetch_abort_out,
  output logic data_done_out,
  output logic data_abort_out
);
  logic [1:0] fiq_dly = 2'h0;
  logic [1:0] irq_dly = 2'h0;
  initial begin
    {fast_low_out, normal_low_out} = 2'h3;
    {fetch_done_out, fetch_abort_out, data_done_out, data_abort_out} = 4'h0;
  end
  always @(posedge clk_in) begin
    fiq_dly <= {fiq_dly[0], fiq_on_in};
    irq_dly <= {irq_dly[0], irq_on_in};
    // Slow sources answer one cycle later
    fast_low_out <= ~(slow_in ? fiq_dly[1] : fiq_dly[0]);
    normal_low_out <= ~(slow_in ? irq_dly[1] : irq_dly[0]);
    fetch_done_out <= fetch_go_in;
    data_done_out <= data_go_in;
    // Abort lines mean nothing without done, so they toggle there
    fetch_abort_out <= fetch_go_in ? fail_in : ~fetch_abort_out;
    data_abort_out <= data_go_in ? fail_in : ~data_abort_out;
  end
endmodule : exc_far_model

/* File: verification/tb_cpu_exception_entry_exit.sv */
// Self-checking bench for the exception entry and exit sequencer
`timescale 1ns/100ps
`include "exc_seq_defs.svh"
module tb_cpu_exception_entry_exit;
  logic sys_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ie = 1'h0, sw = 1'h0, ud = 1'h0, bk = 1'h0;
  logic rs = 1'h0, hv = 1'h0, adv = 1'h0, fl = 1'h0, slow = 1'h0, fon = 1'h0, ion = 1'h0;
  logic fgo = 1'h0, dgo = 1'h0, fail = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, epc = 32'h0, npc = 32'h0, dpc = 32'h0, rdat, exp_st;
  logic fq_n, iq_n, f_done, f_ab, d_done, d_ab, ack, lwe, redir, brs, aband;
  logic [31:0] wb_rd, status, lnk, vec;
  logic [4:0] lmode;
  logic [4:0] modes [3] = '{`MODE_SVC, `MODE_UND, `MODE_ABT};
  logic [31:0] vecs [3] = '{`VEC_SWI, `VEC_UND, `VEC_PREFETCH_ABORT_EXC};
  int bad_count = 0;
  int tests_run = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  exc_far_model far_u (.clk_in(sys_clk_in), .slow_in(slow), .fiq_on_in(fon), .irq_on_in(ion),
    .fetch_go_in(fgo), .data_go_in(dgo), .fail_in(fail), .fast_low_out(fq_n),
    .normal_low_out(iq_n), .fetch_done_out(f_done), .fetch_abort_out(f_ab),
    .data_done_out(d_done), .data_abort_out(d_ab));
  exc_seq dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fast_int_request_low(fq_n),
    .normal_int_request_low(iq_n), .fetch_done_in(f_done), .fetch_abort_in(f_ab),
    .advance_in(adv), .flush_in(fl), .data_done_in(d_done), .data_abort_in(d_ab),
    .data_pc_in(dpc), .instr_end_in(ie), .exec_pc_in(epc), .next_pc_in(npc),
    .software_trap(sw), .undefined_trap(ud), .breakpoint_trap(bk), .restore_in(rs),
    .high_vector_select(hv), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(wb_rd),
    .wb_ack_out(ack), .current_status_word(status), .link_register(lnk),
    .link_write_out(lwe), .link_mode_out(lmode), .redirect_out(redir),
    .vector_addr_out(vec), .base_restore_out(brs), .abandon_out(aband));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rdat = wb_rd;
    {cyc, stb} <= 2'h0;
    if (n >= 20) bad_count++;
  endtask : wb
  task automatic bnd(input logic [2:0] t);
    @(posedge sys_clk_in);
    {ie, bk, ud, sw} <= {1'h1, t};
    epc <= $urandom & 32'hFFFFFFFC;
    npc <= $urandom & 32'hFFFFFFFC;
    @(posedge sys_clk_in);
    {ie, bk, ud, sw} <= 4'h0;
    #1;
  endtask : bnd
  // Model of entry: target mode, I set, native state, F only on request
  task automatic ent(input logic [4:0] m, input logic [31:0] ofs, input logic [31:0] lv,
      input logic setf);
    logic [31:0] prev;
    prev = exp_st;
    exp_st = {exp_st[31:25], 1'h0, exp_st[23:8], 1'h1, exp_st[6] | setf, 1'h0, m};
    chk(redir, 32'h1);
    chk(vec, (hv ? `VEC_HIGH_BASE : 32'h0) | ofs);
    chk(status, exp_st);
    chk({lwe, lmode}, {1'h1, m});
    chk(lnk, lv);
    wb(1'h0, `REG_SAVED, 32'h0);
    chk(rdat, prev);
  endtask : ent
  task automatic pfa(input logic f);
    @(posedge sys_clk_in);
    {fgo, fail} <= 2'h3;
    @(posedge sys_clk_in);
    fgo <= 1'h0;
    repeat (2) @(posedge sys_clk_in);
    {adv, fl} <= {1'h1, f};
    @(posedge sys_clk_in);
    {adv, fl} <= 2'h0;
    bnd(3'h0);
  endtask : pfa
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6000) @(posedge sys_clk_in);
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h5060));
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(aband, 32'h1);
    @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    repeat (2) @(posedge sys_clk_in);
    #1;
    exp_st = `STATUS_RST;
    chk(status, exp_st);
    chk({aband, redir, lwe, vec}, 35'h200000000);
    wb(1'h0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    wb(1'h1, `REG_STATUS, 32'h13);
    exp_st = 32'h13;
    for (int i = 0; i < 3; i++) begin
      hv <= 1'($urandom);
      bnd(3'h1 << i);
      ent(modes[i], vecs[i], epc + 32'h4, 1'h0);
    end
    // Compressed state only reachable by restoring a saved word
    wb(1'h1, `REG_SAVED, 32'h33);
    rs <= 1'h1;
    @(posedge sys_clk_in);
    rs <= 1'h0;
    #1;
    exp_st = 32'h33;
    chk(status, exp_st);
    bnd(3'h2);
    ent(`MODE_UND, `VEC_UND, epc + 32'h2, 1'h0);
    wb(1'h1, `REG_STATUS, 32'h1B);
    exp_st = 32'h1B;
    {fon, ion, slow} <= 3'h7;
    repeat (6) @(posedge sys_clk_in);
    bnd(3'h0);
    ent(`MODE_FIQ, `VEC_FIQ, npc + 32'h4, 1'h1);
    fon <= 1'h0;
    repeat (5) @(posedge sys_clk_in);
    wb(1'h1, `REG_STATUS, 32'h11);
    exp_st = 32'h11;
    bnd(3'h0);
    ent(`MODE_IRQ, `VEC_IRQ, npc + 32'h4, 1'h0);
    bnd(3'h0);
    chk(redir, 32'h0);
    ion <= 1'h0;
    pfa(1'h1);
    chk(redir, 32'h0);
    pfa(1'h0);
    ent(`MODE_ABT, `VEC_PREFETCH_ABORT_EXC, epc + 32'h4, 1'h0);
    @(posedge sys_clk_in);
    {dgo, fail} <= 2'h3;
    dpc <= $urandom & 32'hFFFFFFFC;
    @(posedge sys_clk_in);
    dgo <= 1'h0;
    repeat (2) @(posedge sys_clk_in);
    bnd(3'h1);
    chk(brs, 32'h1);
    ent(`MODE_ABT, `VEC_DATA_ABORT_EXC, dpc + 32'h8, 1'h0);
    test_done();
  end
endmodule : tb_cpu_exception_entry_exit
